// ### hw/emp_map.svh
/*
 * Constants of the external memory port: widths, bank decode, memory
 * type codes and SDRAM timing counts. Assumes a 100 MHz core clock.
 */
// Overview of operation
// - program, data, io buses share one external bus
// - every external access moves one 32-bit word
// - packed instruction fetch reads two consecutive words
// - link lines add sixteen data bits when free
// - async, sync single and sync burst accesses
// - high address bits decoded into bank selects
// - programmable wait states, acknowledge stretches further
// - SDRAM runs at full or half clock
// - standard SDRAM densities driven without glue
// - any or all four banks may be SDRAM
// - optional pipelined SDRAM address and control
// - 24-bit address: 16M words, 4M words per bank
`ifndef EMP_MAP_SVH
`define EMP_MAP_SVH
`define EMP_ADDR_W 24
`define EMP_DATA_W 32
`define EMP_EXTRA_W 16
`define EMP_INSTR_W 48
`define EMP_BANKS 4
`define EMP_BANK_MSB 23
`define EMP_BANK_LSB 22
`define EMP_WS_W 5
`define EMP_CNT_W 6
`define EMP_MT_ASYNC 2'h0
`define EMP_MT_SYNC 2'h1
`define EMP_MT_BURST 2'h2
`define EMP_MT_SDRAM 2'h3
`define EMP_COL_W 10
`define EMP_TRCD_CYC 2
`define EMP_CAS_LAT 2
`define EMP_SYNC_LAT 2
`define EMP_CMD_NOP 3'h7
`define EMP_CMD_ACT 3'h3
`define EMP_CMD_RD 3'h5
`define EMP_CMD_WR 3'h4
`define EMP_CMD_PRE 3'h2
`endif

// ### hw/emp_pkg.sv
/*
 * Types of the external memory port.
 * Assumes emp_map.svh is on the include path.
 */
`include "emp_map.svh"
package emp_pkg;
    typedef logic [`EMP_ADDR_W-1:0] emp_addr_t;
    typedef logic [`EMP_DATA_W-1:0] emp_word_t;
    typedef logic [`EMP_INSTR_W-1:0] emp_instr_t;
    typedef enum logic [3:0] {
        EMP_IDLE, EMP_ADDR, EMP_WAIT, EMP_ACKW,
        EMP_SD_ACT, EMP_SD_CAS, EMP_SD_DATA, EMP_SD_PRE, EMP_DONE
    } emp_state_e;
endpackage

// ### hw/emp_external_port.sv
/*
 * External memory port: arbitrates the program, data and io buses onto
 * one external bus for SRAM, burst SRAM and SDRAM.
 * Assumes static configuration and requests held until their ack.
 */
`timescale 1ns/10ps
`default_nettype none
`include "emp_map.svh"
module emp_external_port
    import emp_pkg::*;
(
    input wire logic clk_in, // core clock
    input wire logic srst_in, // sync reset, high
    input wire logic pm_req_in, // program_memory_bus request
    input wire logic pm_we_in, // program_memory_bus write
    input wire logic pm_fetch_in, // instruction fetch
    input wire emp_addr_t pm_addr_in, // program_memory_bus address
    input wire emp_word_t pm_wdata_in, // program_memory_bus write data
    output logic pm_ack_out, // program_memory_bus done pulse
    input wire logic dm_req_in, // data_memory_bus request
    input wire logic dm_we_in, // data_memory_bus write
    input wire emp_addr_t dm_addr_in, // data_memory_bus address
    input wire emp_word_t dm_wdata_in, // data_memory_bus write data
    output logic dm_ack_out, // data_memory_bus done pulse
    input wire logic io_req_in, // io bus request
    input wire logic io_we_in, // io bus write
    input wire emp_addr_t io_addr_in, // io bus address
    input wire emp_word_t io_wdata_in, // io bus write data
    output logic io_ack_out, // io bus done pulse
    output emp_instr_t rdata_out, // read data, valid with ack
    input wire logic [2*`EMP_BANKS-1:0] bank_type_in, // 2-bit type per bank
    input wire logic [`EMP_WS_W-1:0] wait_states_in, // async wait states
    input wire logic extra_lines_en_in, // link ports off, extra lines in use
    input wire logic sd_half_rate_in, // SDRAM at half clock
    input wire logic sd_pipe_en_in, // pipelined SDRAM addr/control
    output logic [`EMP_ADDR_W-1:0] ext_addr_out, // external address
    input wire logic [`EMP_DATA_W-1:0] ext_data_in, // data pins in
    output logic [`EMP_DATA_W-1:0] ext_data_out, // data pins out
    output logic ext_data_oe_out, // data pins driven
    input wire logic [`EMP_EXTRA_W-1:0] extra_low_data_lines_in, // link lines
    output logic [`EMP_BANKS-1:0] bank_sel_n_out, // bank selects, low
    output logic rd_n_out, // read strobe, low
    output logic wr_n_out, // write strobe, low
    input wire logic ack_in, // external acknowledge, high ready
    output logic sd_ras_n_out, // SDRAM ras, low
    output logic sd_cas_n_out, // SDRAM cas, low
    output logic sd_we_n_out, // SDRAM we, low
    output logic sd_tick_out // SDRAM transfer enable
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic ack_s1_reg, ack_s2_reg;
    logic [`EMP_DATA_W-1:0] dat_s1_reg, dat_s2_reg;
    logic [`EMP_EXTRA_W-1:0] ext_s1_reg, ext_s2_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            dat_s1_reg <= '0;
            dat_s2_reg <= '0;
            ext_s1_reg <= '0;
            ext_s2_reg <= '0;
        end else begin
            ack_s1_reg <= ack_in;
            ack_s2_reg <= ack_s1_reg;
            dat_s1_reg <= ext_data_in;
            dat_s2_reg <= dat_s1_reg;
            ext_s1_reg <= extra_low_data_lines_in;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // ************************************************************
    // SDRAM rate enable
    // ************************************************************
    logic half_reg;
    logic tick;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
        end
    end
    assign tick = sd_half_rate_in ? half_reg : 1'b1;
    assign sd_tick_out = tick;

    // ************************************************************
    // access sequencer
    // ************************************************************
    emp_state_e state_reg;
    emp_addr_t addr_reg;
    emp_word_t wdata_reg;
    emp_instr_t rdata_reg;
    logic we_reg, packed_reg, wide_reg, word_reg;
    logic [1:0] grant_reg;
    logic [1:0] mtype_reg;
    logic [`EMP_CNT_W-1:0] cnt_reg;
    logic [2:0] cmd_reg;
    logic [`EMP_ADDR_W-1:0] pin_addr_reg;
    logic [`EMP_BANKS-1:0] bsel_n_reg;
    logic rd_n_reg, wr_n_reg, oe_reg;
    logic [2:0] done_reg;
    logic [1:0] bank;

    // top address bits pick the bank; SRAM accesses drive the whole address onto the pins
    assign bank = addr_reg[`EMP_BANK_MSB:`EMP_BANK_LSB];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= EMP_IDLE;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            we_reg <= 1'b0;
            packed_reg <= 1'b0;
            wide_reg <= 1'b0;
            word_reg <= 1'b0;
            grant_reg <= 2'h0;
            mtype_reg <= `EMP_MT_ASYNC;
            cnt_reg <= '0;
            cmd_reg <= `EMP_CMD_NOP;
            pin_addr_reg <= '0;
            bsel_n_reg <= '1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            done_reg <= 3'h0;
        end else begin
            done_reg <= 3'h0;
            unique case (state_reg)
                EMP_IDLE: begin
                    // fixed priority: data, then program, then io
                    if (dm_req_in || pm_req_in || io_req_in) begin
                        packed_reg <= 1'b0;
                        wide_reg <= 1'b0;
                        if (dm_req_in) begin
                            grant_reg <= 2'h0;
                            addr_reg <= dm_addr_in;
                            we_reg <= dm_we_in;
                            wdata_reg <= dm_wdata_in;
                            mtype_reg <= bank_type_in[2*dm_addr_in[23:22] +: 2];
                        end else if (pm_req_in) begin
                            grant_reg <= 2'h1;
                            addr_reg <= pm_addr_in;
                            we_reg <= pm_we_in;
                            wdata_reg <= pm_wdata_in;
                            // instruction: two words, or one plus link lines
                            packed_reg <= pm_fetch_in && !pm_we_in && !extra_lines_en_in;
                            wide_reg <= pm_fetch_in && !pm_we_in && extra_lines_en_in;
                            mtype_reg <= bank_type_in[2*pm_addr_in[23:22] +: 2];
                        end else begin
                            grant_reg <= 2'h2;
                            addr_reg <= io_addr_in;
                            we_reg <= io_we_in;
                            wdata_reg <= io_wdata_in;
                            mtype_reg <= bank_type_in[2*io_addr_in[23:22] +: 2];
                        end
                        word_reg <= 1'b0;
                        rdata_reg <= '0;
                        state_reg <= EMP_ADDR;
                    end
                end
                EMP_ADDR: begin
                    pin_addr_reg <= addr_reg;
                    bsel_n_reg <= ~(`EMP_BANKS'(1) << bank);
                    oe_reg <= we_reg;
                    if (mtype_reg == `EMP_MT_SDRAM) begin
                        // upper twelve bits of the in-bank word address open the row
                        pin_addr_reg <= `EMP_ADDR_W'(addr_reg[`EMP_BANK_LSB-1:`EMP_COL_W]);
                        cmd_reg <= `EMP_CMD_ACT;
                        cnt_reg <= `EMP_CNT_W'(`EMP_TRCD_CYC);
                        state_reg <= EMP_SD_ACT;
                    end else begin
                        rd_n_reg <= we_reg;
                        wr_n_reg <= !we_reg;
                        // sync parts sample on the clock, no wait states
                        cnt_reg <= (mtype_reg == `EMP_MT_ASYNC) ?
                            `EMP_CNT_W'(wait_states_in) : '0;
                        state_reg <= EMP_WAIT;
                    end
                end
                EMP_WAIT: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        state_reg <= EMP_ACKW;
                    end
                end
                EMP_ACKW: begin
                    // ack and data pass the same two stages, so they line up
                    if (ack_s2_reg) begin
                        if (word_reg) begin
                            rdata_reg[`EMP_INSTR_W-1:`EMP_DATA_W] <= dat_s2_reg[`EMP_EXTRA_W-1:0];
                        end else begin
                            rdata_reg[`EMP_DATA_W-1:0] <= dat_s2_reg;
                            if (wide_reg) begin
                                rdata_reg[`EMP_INSTR_W-1:`EMP_DATA_W] <= ext_s2_reg;
                            end
                        end
                        if (packed_reg && !word_reg) begin
                            word_reg <= 1'b1;
                            addr_reg <= addr_reg + 1'b1;
                            if (mtype_reg == `EMP_MT_BURST) begin
                                // burst part steps on with strobes held
                                pin_addr_reg <= addr_reg + 1'b1;
                                cnt_reg <= `EMP_CNT_W'(`EMP_SYNC_LAT);
                                state_reg <= EMP_WAIT;
                            end else begin
                                rd_n_reg <= 1'b1;
                                state_reg <= EMP_ADDR;
                            end
                        end else begin
                            rd_n_reg <= 1'b1;
                            wr_n_reg <= 1'b1;
                            oe_reg <= 1'b0;
                            bsel_n_reg <= '1;
                            state_reg <= EMP_DONE;
                        end
                    end
                end
                EMP_SD_ACT: begin
                    if (tick) begin
                        cmd_reg <= `EMP_CMD_NOP;
                        if (cnt_reg > `EMP_CNT_W'(1)) begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end else begin
                            pin_addr_reg <= `EMP_ADDR_W'(addr_reg[`EMP_COL_W-1:0]);
                            cmd_reg <= we_reg ? `EMP_CMD_WR : `EMP_CMD_RD;
                            // pipelined outputs and pin stages delay the data
                            cnt_reg <= `EMP_CNT_W'(`EMP_CAS_LAT + `EMP_SYNC_LAT) +
                                `EMP_CNT_W'(sd_pipe_en_in);
                            state_reg <= we_reg ? EMP_SD_PRE : EMP_SD_CAS;
                        end
                    end
                end
                EMP_SD_CAS: begin
                    if (tick) begin
                        cmd_reg <= `EMP_CMD_NOP;
                        cnt_reg <= cnt_reg - 1'b1;
                        if (cnt_reg == `EMP_CNT_W'(1)) begin
                            state_reg <= EMP_SD_DATA;
                        end
                    end
                end
                EMP_SD_DATA: begin
                    if (word_reg) begin
                        rdata_reg[`EMP_INSTR_W-1:`EMP_DATA_W] <= dat_s2_reg[`EMP_EXTRA_W-1:0];
                    end else begin
                        rdata_reg[`EMP_DATA_W-1:0] <= dat_s2_reg;
                        if (wide_reg) begin
                            rdata_reg[`EMP_INSTR_W-1:`EMP_DATA_W] <= ext_s2_reg;
                        end
                    end
                    state_reg <= EMP_SD_PRE;
                end
                EMP_SD_PRE: begin
                    if (tick) begin
                        cmd_reg <= `EMP_CMD_PRE;
                        oe_reg <= 1'b0;
                        if (packed_reg && !word_reg) begin
                            word_reg <= 1'b1;
                            addr_reg <= addr_reg + 1'b1;
                            state_reg <= EMP_ADDR;
                        end else begin
                            state_reg <= EMP_DONE;
                            bsel_n_reg <= '1;
                        end
                    end
                end
                EMP_DONE: begin
                    if (tick) begin
                        cmd_reg <= `EMP_CMD_NOP;
                    end
                    done_reg <= 3'h1 << grant_reg;
                    state_reg <= EMP_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // output stage
    // ************************************************************
    // one extra register lets board buffers sit before wide SDRAM arrays
    logic [2:0] cmd_p_reg;
    logic [`EMP_ADDR_W-1:0] addr_p_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_p_reg <= `EMP_CMD_NOP;
            addr_p_reg <= '0;
        end else begin
            cmd_p_reg <= cmd_reg;
            addr_p_reg <= pin_addr_reg;
        end
    end
    assign {sd_ras_n_out, sd_cas_n_out, sd_we_n_out} = sd_pipe_en_in ? cmd_p_reg : cmd_reg;
    assign ext_addr_out = sd_pipe_en_in ? addr_p_reg : pin_addr_reg;
    assign ext_data_out = wdata_reg;
    assign ext_data_oe_out = oe_reg;
    assign bank_sel_n_out = bsel_n_reg;
    assign rd_n_out = rd_n_reg;
    assign wr_n_out = wr_n_reg;
    assign rdata_out = rdata_reg;
    assign dm_ack_out = done_reg[0];
    assign pm_ack_out = done_reg[1];
    assign io_ack_out = done_reg[2];
endmodule
`default_nettype wire

// ### sim/emp_external_port_props.sv
/* Checker of the port pins and done pulses.
   Bound to the port from the testbench top; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "emp_map.svh"
module emp_external_port_props (
    input wire logic clk_in, // core clock
    input wire logic srst_in, // sync reset
    input wire logic pm_ack_out, // program done
    input wire logic dm_ack_out, // data done
    input wire logic io_ack_out, // io done
    input wire logic [4:0] wait_states_in, // wait states
    input wire logic sd_half_rate_in, // half rate
    input wire logic ack_in, // external ack
    input wire logic [23:0] ext_addr_out, // address
    input wire logic ext_data_oe_out, // data drive
    input wire logic [3:0] bank_sel_n_out, // bank selects
    input wire logic rd_n_out, // read strobe
    input wire logic wr_n_out, // write strobe
    input wire logic sd_ras_n_out, // ras
    input wire logic sd_cas_n_out, // cas
    input wire logic sd_we_n_out, // we
    input wire logic sd_tick_out // transfer enable
);
    // ****
    // pin checks
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire logic any_ack = pm_ack_out | dm_ack_out | io_ack_out;
    wire logic [2:0] cmd = {sd_ras_n_out, sd_cas_n_out, sd_we_n_out};
    logic [5:0] low_cnt;
    // saturates so long stalls cannot wrap the count
    always_ff @(posedge clk_in) begin
        if (srst_in || rd_n_out) begin
            low_cnt <= 6'h0;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h1;
        end
    end
    AST_ONE_ACK: assert property ($onehot0({pm_ack_out, dm_ack_out, io_ack_out}))
        else $error("two done pulses at once");
    AST_ACK_GAP: assert property (any_ack |=> !any_ack [*4])
        else $error("done pulses too close");
    AST_ONE_STROBE: assert property (rd_n_out || wr_n_out)
        else $error("read and write strobes together");
    AST_BANK_ONEHOT: assert property ($onehot0(~bank_sel_n_out))
        else $error("several banks selected");
    AST_BANK_DECODE: assert property (!(rd_n_out && wr_n_out) |->
        bank_sel_n_out == ~(4'h1 << ext_addr_out[23:22])) else $error("bank select wrong");
    AST_READ_RELEASED: assert property (!rd_n_out |-> !ext_data_oe_out)
        else $error("data driven during read");
    AST_WRITE_DRIVEN: assert property (!wr_n_out |-> ext_data_oe_out)
        else $error("data not driven during write");
    AST_ACK_HOLD: assert property ((!rd_n_out && !ack_in) [*3] |=> !rd_n_out)
        else $error("read ended without acknowledge");
    AST_WAIT_MIN: assert property ($rose(rd_n_out) |-> low_cnt > {1'b0, wait_states_in})
        else $error("read shorter than wait states");
    AST_SD_CMD: assert property (cmd inside {3'h7, 3'h3, 3'h5, 3'h4, 3'h2})
        else $error("illegal sdram command");
    AST_RESET_IDLE: assert property ($fell(srst_in) |-> cmd == 3'h7 &&
        bank_sel_n_out == 4'hf && rd_n_out && wr_n_out) else $error("not idle after reset");
    AST_FULL_TICK: assert property (!sd_half_rate_in [*3] |-> sd_tick_out)
        else $error("tick missing at full rate");
    AST_HALF_TICK: assert property (sd_half_rate_in [*3] |-> sd_tick_out != $past(sd_tick_out))
        else $error("tick not alternating");
endmodule
`default_nettype wire

// ### sim/emp_mem_model.sv
/* Behavioural external SRAM and SDRAM with acknowledge.
   Assumes the port pins are wired straight to it. */
`timescale 1ns/10ps
`default_nettype none
`include "emp_map.svh"
module emp_mem_model
    import emp_pkg::*;
#(parameter emp_word_t SD_WORD = 32'h5a5a_c3c3)
(
    input wire logic clk_in, // core clock
    input wire emp_addr_t addr_in, // address pins
    input wire logic [3:0] bank_sel_n_in, // bank selects
    input wire logic rd_n_in, // read strobe
    input wire logic wr_n_in, // write strobe
    input wire emp_word_t wdata_in, // data from port
    input wire logic [2:0] cmd_in, // ras cas we
    input wire logic stall_in, // keep ack low
    output emp_word_t data_out, // data to port
    output logic [15:0] extra_out, // link lines
    output logic ack_out, // acknowledge
    output emp_addr_t wr_addr_out, // last write address
    output emp_word_t wr_data_out, // last write data
    output logic [7:0] rd_cnt_out, // strobed reads
    output logic [7:0] act_cnt_out, // activates
    output logic [7:0] sdrd_cnt_out // sdram reads
);
    // ****
    // memory behaviour
    // ****
    logic [2:0] cmd_q = 3'h7;
    logic [3:0] hold = 4'h0;
    wire logic sel = bank_sel_n_in != 4'hf;
    initial {data_out, extra_out, ack_out, rd_cnt_out, act_cnt_out, sdrd_cnt_out} = '0;
    always @(posedge clk_in) begin
        cmd_q <= cmd_in;
        ack_out <= sel && !(rd_n_in && wr_n_in) && !stall_in;
        if (sel && !rd_n_in) begin
            data_out <= {~addr_in[7:0], addr_in};
            extra_out <= ~addr_in[15:0];
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end else begin
            // released lines do not keep their last value
            data_out <= ~data_out;
            extra_out <= ~extra_out;
        end
        if ($fell(rd_n_in)) rd_cnt_out <= rd_cnt_out + 8'h1;
        if (!wr_n_in && sel) begin
            wr_addr_out <= addr_in;
            wr_data_out <= wdata_in;
        end
        if (cmd_in != cmd_q && cmd_in == `EMP_CMD_ACT) act_cnt_out <= act_cnt_out + 8'h1;
        if (cmd_in != cmd_q && cmd_in == `EMP_CMD_RD) begin
            sdrd_cnt_out <= sdrd_cnt_out + 8'h1;
            data_out <= SD_WORD;
            hold <= 4'hd;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb_emp_external_port.sv
/* Bench of the external memory port with a memory model.
   Assumes emp_pkg is compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_emp_external_port import emp_pkg::*;;
    localparam emp_word_t SD_WORD = 32'h5a5a_c3c3;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [2:0] req, we;
    logic pm_fetch_in, extra_lines_en_in, sd_half_rate_in, sd_pipe_en_in, stall;
    emp_addr_t addr [3];
    emp_word_t wd [3];
    logic [7:0] bank_type_in;
    logic [4:0] wait_states_in;
    wire logic [2:0] ack;
    wire emp_instr_t rdata_out;
    wire emp_addr_t ext_addr_out, wr_a;
    wire emp_word_t ext_data_in, ext_data_out, mem_d, wr_d;
    wire logic [15:0] extra_low_data_lines_in;
    wire logic [3:0] bank_sel_n_out;
    wire logic ext_data_oe_out, rd_n_out, wr_n_out, ack_in, sd_tick_out;
    wire logic sd_ras_n_out, sd_cas_n_out, sd_we_n_out;
    wire logic [7:0] rd_cnt, act_cnt, sdrd_cnt;
    emp_instr_t got;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    // ****
    // harness
    // ****
    always #5 clk_in = ~clk_in;
    assign ext_data_in = ext_data_oe_out ? ext_data_out : mem_d;
    emp_external_port u_dut (.clk_in, .srst_in, .pm_req_in(req[1]), .pm_we_in(we[1]),
        .pm_fetch_in, .pm_addr_in(addr[1]), .pm_wdata_in(wd[1]), .pm_ack_out(ack[1]),
        .dm_req_in(req[0]), .dm_we_in(we[0]), .dm_addr_in(addr[0]), .dm_wdata_in(wd[0]),
        .dm_ack_out(ack[0]), .io_req_in(req[2]), .io_we_in(we[2]), .io_addr_in(addr[2]),
        .io_wdata_in(wd[2]), .io_ack_out(ack[2]), .rdata_out, .bank_type_in, .wait_states_in,
        .extra_lines_en_in, .sd_half_rate_in, .sd_pipe_en_in, .ext_addr_out, .ext_data_in,
        .ext_data_out, .ext_data_oe_out, .extra_low_data_lines_in, .bank_sel_n_out, .rd_n_out,
        .wr_n_out, .ack_in, .sd_ras_n_out, .sd_cas_n_out, .sd_we_n_out, .sd_tick_out);
    emp_mem_model #(.SD_WORD(SD_WORD)) u_mem (.clk_in, .addr_in(ext_addr_out),
        .bank_sel_n_in(bank_sel_n_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
        .wdata_in(ext_data_out), .cmd_in({sd_ras_n_out, sd_cas_n_out, sd_we_n_out}),
        .stall_in(stall), .data_out(mem_d), .extra_out(extra_low_data_lines_in),
        .ack_out(ack_in), .wr_addr_out(wr_a), .wr_data_out(wr_d), .rd_cnt_out(rd_cnt),
        .act_cnt_out(act_cnt), .sdrd_cnt_out(sdrd_cnt));
    function automatic emp_word_t pat(emp_addr_t a);
        return {~a[7:0], a};
    endfunction
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until its own done pulse, then one idle cycle
    task automatic acc(input int b, input logic w, f, input emp_addr_t a, input emp_word_t d);
        int n = 0;
        {we[b], addr[b], wd[b], pm_fetch_in, req[b]} = {w, a, d, f, 1'b1};
        while (ack[b] !== 1'b1 && n < 300) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        got = rdata_out;
        req[b] = 1'b0;
        check("done pulse", n < 300, 1'b1);
        @(posedge clk_in);
        #1;
    endtask
    // ****
    // scenarios
    // ****
    task automatic sc_reads();
        emp_addr_t a;
        for (int t = 0; t < 3; t++) begin
            for (int b = 0; b < 3; b++) begin
                a = {2'(b + t), 22'h2a5 + 22'(b)};
                bank_type_in = {4{2'(t)}};
                wait_states_in = (t == 0) ? 5'(b * 15) : 5'h0;
                acc(b, 1'b0, 1'b0, a, 32'h0);
                check("read word", got[31:0], pat(a));
            end
        end
        bank_type_in = 8'h00;
        wait_states_in = 5'h1f;
        acc(0, 1'b0, 1'b0, 24'hff_fffe, 32'h0);
        check("top word", got[31:0], pat(24'hff_fffe));
        wait_states_in = 5'h2;
        acc(0, 1'b1, 1'b0, 24'h80_0123, 32'hdead_0042);
        check("write addr", wr_a, 24'h80_0123);
        check("write data", wr_d, 32'hdead_0042);
    endtask
    task automatic sc_priority();
        logic [5:0] ord = 6'h0;
        int n = 0;
        addr = '{24'h00_0011, 24'h00_0022, 24'h00_0033};
        we = 3'h0;
        req = 3'h7;
        while (req != 3'h0 && n < 600) begin
            @(posedge clk_in);
            #1;
            n++;
            for (int i = 0; i < 3; i++) if (ack[i] === 1'b1) begin
                ord = {ord[3:0], 2'(i)};
                req[i] = 1'b0;
            end
        end
        check("grant order", ord, 6'h06);
        @(posedge clk_in);
        #1;
    endtask
    task automatic sc_fetch();
        logic [7:0] n;
        for (int t = 0; t < 3; t += 2) begin
            bank_type_in = {4{2'(t)}};
            extra_lines_en_in = 1'b0;
            acc(1, 1'b0, 1'b1, 24'h40_1000, 32'h0);
            check("packed low", got[31:0], pat(24'h40_1000));
            check("packed high", got[47:32], 16'(pat(24'h40_1001)));
            n = rd_cnt;
            extra_lines_en_in = 1'b1;
            acc(1, 1'b0, 1'b1, 24'h40_1000, 32'h0);
            check("extra high", got[47:32], 16'hefff);
            check("one access", 8'(rd_cnt - n), 8'h1);
        end
        extra_lines_en_in = 1'b0;
    endtask
    task automatic sc_stall();
        logic seen = 1'b0;
        {bank_type_in, wait_states_in, stall} = {8'h00, 5'h0, 1'b1};
        fork
            acc(0, 1'b0, 1'b0, 24'h00_0abc, 32'h0);
            begin
                repeat (25) begin
                    @(posedge clk_in);
                    #1;
                    seen = seen | ack[0];
                end
                stall = 1'b0;
            end
        join
        check("held", seen, 1'b0);
        check("late word", got[31:0], pat(24'h00_0abc));
    endtask
    task automatic sc_sdram();
        logic [7:0] na, nr;
        bank_type_in = 8'hff;
        for (int m = 0; m < 4; m++) begin
            {sd_pipe_en_in, sd_half_rate_in} = 2'(m);
            {na, nr} = {act_cnt, sdrd_cnt};
            acc(m % 3, 1'b0, 1'b0, {2'(m), 22'h15_5aa5}, 32'h0);
            check("sdram word", got[31:0], SD_WORD);
            check("activates", 8'(act_cnt - na), 8'h1);
            check("sdram reads", 8'(sdrd_cnt - nr), 8'h1);
            acc(2, 1'b1, 1'b0, {2'(3 - m), 22'h00_0100}, 32'h0f0f_0f0f);
        end
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {req, we, pm_fetch_in, extra_lines_en_in, sd_half_rate_in, sd_pipe_en_in} = '0;
        {bank_type_in, wait_states_in, stall} = '0;
        addr = '{default: 24'h0};
        wd = '{default: 32'h0};
        repeat (12) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        check("idle pins", {bank_sel_n_out, rd_n_out, wr_n_out, ext_data_oe_out, ack,
            sd_ras_n_out, sd_cas_n_out, sd_we_n_out}, {4'hf, 3'h6, 3'h0, 3'h7});
        sc_reads();
        sc_priority();
        sc_fetch();
        sc_stall();
        sc_sdram();
        complete_run();
    end
endmodule
bind emp_external_port emp_external_port_props u_props (.clk_in, .srst_in, .pm_ack_out,
    .dm_ack_out, .io_ack_out, .wait_states_in, .sd_half_rate_in, .ack_in, .ext_addr_out,
    .ext_data_oe_out, .bank_sel_n_out, .rd_n_out, .wr_n_out, .sd_ras_n_out, .sd_cas_n_out,
    .sd_we_n_out, .sd_tick_out);
`default_nettype wire
